// File: bench/adc_trigger_pacer_control_tb.sv
// Register-driven testbench for the trigger/pacer block
`timescale 1ns/10ps
module adc_trigger_pacer_control_tb
  import atp_pkg::*;
;
  localparam logic [3:0] SP = ATP_OFF_SCAN_PACER;
  localparam logic [3:0] TC = ATP_OFF_TRIG_CTRL;
  logic        clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        data_wr = 1'b0, conversion_done = 1'b0, counter_pacer = 1'b0;
  logic        adc_fifo_half_full = 1'b0, pre_index_done = 1'b0;
  logic        trig_lvl = 1'b0, pace_lvl = 1'b0, ucl_lvl = 1'b0;
  logic [1:0]  ana_lvl = 2'h1;
  logic [3:0]  reg_addr = 4'h0, mux_channel;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic        ext_trigger_pin, ext_pacer_pin, above_upper, below_lower;
  logic        user_counter_clock_pin, convert_start, trigger_flop_state;
  logic        acq_gate, analog_trigger_out, sample_counter_arm;
  logic        sample_counter_clk_en, user_counter_clk_en;
  logic        burst_mode, pretrig_mode;
  int          miscompares = 0, check_count = 0, conv_cnt = 0, ucnt = 0;
  int          n0, cyc_cnt = 0;
  // Analog cases: control word, comparator level, expected output
  logic [23:0] atab [18] = '{24'h000321, 24'h000311, 24'h000300,
    24'h000310, 24'h040301, 24'h040311, 24'h040320, 24'h040310,
    24'h010301, 24'h010310, 24'h010320, 24'h060321, 24'h060310,
    24'h060300, 24'h030311, 24'h030320, 24'h030300, 24'h030311};

  atp_trigger_pacer dut (
    .clk, .rst_n, .reg_wr, .reg_rd, .data_wr, .reg_addr, .reg_wdata,
    .reg_rdata, .conversion_done, .counter_pacer, .adc_fifo_half_full,
    .pre_index_done, .ext_trigger_pin, .ext_pacer_pin, .above_upper,
    .below_lower, .user_counter_clock_pin, .convert_start, .mux_channel,
    .trigger_flop_state, .acq_gate, .analog_trigger_out,
    .sample_counter_arm, .sample_counter_clk_en, .user_counter_clk_en,
    .burst_mode, .pretrig_mode
  );
  atp_src_model u_src (
    .trig_lvl, .pace_lvl, .ucl_lvl, .ana_lvl, .ext_trigger_pin,
    .ext_pacer_pin, .user_counter_clock_pin, .above_upper, .below_lower
  );

  always #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (miscompares == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // The run needs about 850 cycles; a hang is cut well past that
  always @(posedge clk) begin
    conv_cnt <= conv_cnt + int'(convert_start === 1'b1);
    ucnt <= ucnt + int'(user_counter_clk_en === 1'b1);
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 8000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One strobe: k 0 register write, 1 read and compare, 2 data write
  task automatic acc(input int k, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = (k == 0);
    reg_rd = (k == 1);
    data_wr = (k == 2);
    @(posedge clk);
    #1;
    {reg_wr, reg_rd, data_wr} = 3'h0;
    if (k == 1)
      chk(reg_rdata, d);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(12);
    rst_n = 1'b1;
    conversion_done = 1'b1;
    acc(1, SP, 16'h4000);
    acc(1, TC, 16'h0000);
    conversion_done = 1'b0;
    pre_index_done = 1'b1;
    acc(1, SP, 16'h0000);
    acc(1, TC, 16'h1000);
    acc(1, 4'h8, 16'h0000);
    pre_index_done = 1'b0;
    acc(0, SP, 16'h00FE);
    cyc(2);
    for (int i = 0; i < 3; i++) begin
      chk(mux_channel, 4'hE + i[0]);
      conversion_done = 1'b1;
      cyc(3);
      conversion_done = 1'b0;
      cyc(3);
    end
    for (int m = 0; m < 4; m++) begin
      acc(0, SP, {2'h0, m[1:0], 12'h000});
      n0 = conv_cnt;
      acc(2, ATP_OFF_ADC_DATA, 16'hFFFF);
      counter_pacer = 1'b1;
      cyc(4);
      counter_pacer = 1'b0;
      pace_lvl = 1'b1;
      cyc(6);
      chk(16'(conv_cnt - n0), 16'(m != 2));
      pace_lvl = 1'b0;
      cyc(6);
      chk(16'(conv_cnt - n0), 16'h0001);
    end
    acc(0, SP, 16'h1000);
    acc(0, TC, 16'h001E);
    trig_lvl = 1'b1;
    cyc(8);
    acc(1, TC, 16'h0000);
    trig_lvl = 1'b0;
    cyc(8);
    acc(1, TC, 16'h0080);
    acc(0, TC, 16'h001E);
    acc(1, TC, 16'h0080);
    acc(0, TC, 16'h009E);
    acc(1, TC, 16'h0000);
    acc(0, TC, 16'h001A);
    for (int i = 0; i < 2; i++) begin
      trig_lvl = 1'b1;
      cyc(8);
      acc(1, TC, 16'h0080);
      trig_lvl = 1'b0;
      cyc(4);
    end
    acc(0, TC, 16'h0080);
    acc(0, TC, 16'h000A);
    trig_lvl = 1'b1;
    cyc(8);
    acc(1, TC, 16'h0000);
    trig_lvl = 1'b0;
    acc(0, TC, 16'h0012);
    for (int g = 0; g < 2; g++) begin
      trig_lvl = g[0];
      cyc(6);
      n0 = conv_cnt;
      counter_pacer = 1'b1;
      cyc(6);
      counter_pacer = 1'b0;
      chk(16'(conv_cnt - n0), 16'(g));
      chk(16'(acq_gate), 16'(g));
    end
    trig_lvl = 1'b0;
    acc(0, TC, 16'h0001);
    acc(0, TC, 16'h0011);
    // Enable is stored first; the trigger needs a write with it already set
    acc(0, TC, 16'h0011);
    cyc(4);
    acc(1, TC, 16'h0080);
    acc(0, TC, 16'h0851);
    cyc(4);
    chk(sample_counter_arm, 1'b0);
    pre_index_done = 1'b1;
    cyc(4);
    chk(sample_counter_arm, 1'b1);
    pre_index_done = 1'b0;
    acc(0, TC, 16'h0080);
    acc(0, TC, 16'h0800);
    adc_fifo_half_full = 1'b1;
    cyc(4);
    chk({sample_counter_arm, sample_counter_clk_en}, 2'b11);
    adc_fifo_half_full = 1'b0;
    acc(0, TC, 16'h0060);
    cyc(2);
    chk({burst_mode, pretrig_mode}, 2'b11);
    foreach (atab[i]) begin
      acc(0, TC, atab[i][23:8]);
      ana_lvl = atab[i][5:4];
      cyc(8);
      chk(analog_trigger_out, atab[i][0]);
    end
    chk({burst_mode, pretrig_mode}, 2'b00);
    for (int s = 1; s >= 0; s--) begin
      acc(0, TC, {2'h0, s[0], 13'h0000});
      cyc(4);
      n0 = ucnt;
      repeat (5) begin
        ucl_lvl = 1'b1;
        cyc(20);
        ucl_lvl = 1'b0;
        cyc(20);
      end
      chk(16'(ucnt - n0), s[0] ? 16'h000A : 16'h0005);
    end
    end_sim();
  end
endmodule // adc_trigger_pacer_control_tb

// File: bench/atp_checker.sv
// Port-level assertions for the trigger/pacer block
`timescale 1ns/10ps
module atp_checker
  import atp_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic        data_wr,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        conversion_done,
  input wire logic        pre_index_done,
  input wire logic        ext_trigger_pin,
  input wire logic        above_upper,
  input wire logic        below_lower,
  input wire logic        convert_start,
  input wire logic        trigger_flop_state,
  input wire logic        analog_trigger_out,
  input wire logic        user_counter_clk_en,
  input wire logic        burst_mode,
  input wire logic        pretrig_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] tc_ff;
  logic [1:0]  pace_ff;
  logic        clr_w;
  logic        tc_w;
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of the control fields that the outputs hang on
  assign tc_w = reg_wr && reg_addr == ATP_OFF_TRIG_CTRL;
  assign clr_w = tc_w && reg_wdata[ATP_TC_CLR_BIT];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      tc_ff <= ATP_TC_RESET;
    else if (tc_w)
      tc_ff <= reg_wdata;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      pace_ff <= ATP_PACE_SW;
    else if (reg_wr && reg_addr == ATP_OFF_SCAN_PACER)
      pace_ff <= reg_wdata[13:12];
  end
  ////////////////////////////////////////////////////////////////////////////
  AST_DONE_LIVE: assert property (
    reg_rd && reg_addr == ATP_OFF_SCAN_PACER
    |=> reg_rdata[ATP_SP_DONE_BIT] == $past(conversion_done))
    else $error("done bit wrong");
  AST_INDEX_READ: assert property (
    reg_rd && reg_addr == ATP_OFF_TRIG_CTRL
    |=> reg_rdata[ATP_TC_INDEX_BIT] == $past(pre_index_done))
    else $error("index bit wrong");
  AST_SW_CONVERT: assert property (
    data_wr && reg_addr == ATP_OFF_ADC_DATA && pace_ff == ATP_PACE_SW
    |-> ##[1:2] convert_start)
    else $error("no software conversion");
  AST_FLOP_CLEAR: assert property (
    clr_w && reg_wdata[1:0] == ATP_TRIG_OFF |-> ##[1:3] !trigger_flop_state)
    else $error("flop not cleared");
  AST_FLOP_HELD: assert property (
    $fell(trigger_flop_state)
    |-> $past(clr_w) || $past(clr_w, 2) || $past(clr_w, 3))
    else $error("flop fell without clear");
  AST_EXT_EDGE: assert property (
    $rose(ext_trigger_pin) && tc_ff[1:0] == ATP_TRIG_DIG
    && tc_ff[4:2] == 3'b110 |-> ##[2:6] trigger_flop_state)
    else $error("edge did not set flop");
  AST_NEEDS_ENABLE: assert property (
    $rose(trigger_flop_state) |-> tc_ff[ATP_TC_EN_BIT])
    else $error("flop set while disabled");
  AST_UCLK_TICK: assert property (
    tc_ff[ATP_TC_UCLK_BIT] && user_counter_clk_en
    |-> ##20 (user_counter_clk_en || !tc_ff[ATP_TC_UCLK_BIT]))
    else $error("user tick period wrong");
  AST_MODE_COPY: assert property (
    tc_w |-> ##2 burst_mode == tc_ff[ATP_TC_BURST_BIT]
    && pretrig_mode == tc_ff[ATP_TC_PRE_BIT])
    else $error("mode copy wrong");
  AST_WINDOW: assert property (
    (tc_ff[9:8] == 2'b11 && !above_upper && !below_lower) [*6]
    |-> analog_trigger_out)
    else $error("window output low");
  cover property ($rose(trigger_flop_state));
  cover property (convert_start);
  cover property ($rose(analog_trigger_out));
endmodule // atp_checker

bind atp_trigger_pacer atp_checker u_chk (
  .clk, .rst_n, .reg_wr, .reg_rd, .data_wr, .reg_addr, .reg_wdata,
  .reg_rdata, .conversion_done, .pre_index_done, .ext_trigger_pin,
  .above_upper, .below_lower, .convert_start, .trigger_flop_state,
  .analog_trigger_out, .user_counter_clk_en, .burst_mode, .pretrig_mode
);

// File: bench/atp_src_model.sv
// Far-side model: external trigger, pacer, user clock and comparator sources
`timescale 1ns/10ps
module atp_src_model (
  input  wire logic       trig_lvl,
  input  wire logic       pace_lvl,
  input  wire logic       ucl_lvl,
  input  wire logic [1:0] ana_lvl,
  output logic            ext_trigger_pin,
  output logic            ext_pacer_pin,
  output logic            user_counter_clock_pin,
  output logic            above_upper,
  output logic            below_lower
);
  // Trigger, pacer and user clock pins move off the clock grid; comparator pins land on a clock edge
  assign #3 ext_trigger_pin = trig_lvl;
  assign #3 ext_pacer_pin = pace_lvl;
  assign #2 user_counter_clock_pin = ucl_lvl;
  // Level 2 is above upper, 0 below lower, 1 between: never both set
  assign #4 above_upper = (ana_lvl == 2'h2);
  assign #4 below_lower = (ana_lvl == 2'h0);
endmodule // atp_src_model

// File: verilog/atp_pkg.sv
// Package: register offsets, field positions and encodings of the trigger/pacer block
package atp_pkg;
  // Register offsets (16-bit I/O words)
  localparam logic [3:0] ATP_OFF_FIFO_STAT   = 4'h0;
  localparam logic [3:0] ATP_OFF_SCAN_PACER  = 4'h2;
  localparam logic [3:0] ATP_OFF_TRIG_CTRL   = 4'h4;
  // ADC data register sits on its own decode (separate region)
  localparam logic [3:0] ATP_OFF_ADC_DATA    = 4'h0;

  // adc_scan_pacer_control fields
  localparam int ATP_SP_FIRST_LSB  = 0;
  localparam int ATP_SP_LAST_LSB   = 4;
  localparam int ATP_SP_PACER_LSB  = 12;
  localparam int ATP_SP_DONE_BIT   = 14;

  // trigger_control_status fields
  localparam int ATP_TC_TSEL_LSB   = 0;
  localparam int ATP_TC_INV_BIT    = 2;
  localparam int ATP_TC_EDGE_BIT   = 3;
  localparam int ATP_TC_EN_BIT     = 4;
  localparam int ATP_TC_BURST_BIT  = 5;
  localparam int ATP_TC_PRE_BIT    = 6;
  localparam int ATP_TC_CLR_BIT    = 7;
  localparam int ATP_TC_LOEN_BIT   = 8;
  localparam int ATP_TC_HIEN_BIT   = 9;
  localparam int ATP_TC_HYST_BIT   = 10;
  localparam int ATP_TC_ARM_BIT    = 11;
  localparam int ATP_TC_SHORT_BIT  = 12;
  localparam int ATP_TC_UCLK_BIT   = 13;
  localparam int ATP_TC_FLOP_BIT   = 7;
  localparam int ATP_TC_INDEX_BIT  = 12;

  // Reset values
  localparam logic [15:0] ATP_SP_RESET = 16'h0000;
  localparam logic [15:0] ATP_TC_RESET = 16'h0000;

  // Encodings
  localparam logic [1:0] ATP_PACE_SW   = 2'h0;
  localparam logic [1:0] ATP_PACE_CTR  = 2'h1;
  localparam logic [1:0] ATP_PACE_FALL = 2'h2;
  localparam logic [1:0] ATP_PACE_RISE = 2'h3;
  localparam logic [1:0] ATP_TRIG_OFF  = 2'h0;
  localparam logic [1:0] ATP_TRIG_SW   = 2'h1;
  localparam logic [1:0] ATP_TRIG_DIG  = 2'h2;
  localparam logic [1:0] ATP_TRIG_ANA  = 2'h3;

  // Timing: 200 MHz clock, 10 MHz counter reference
  localparam int ATP_CLK_MHZ     = 200;
  localparam int ATP_REF_MHZ     = 10;
  localparam int ATP_REF_DIV     = ATP_CLK_MHZ / ATP_REF_MHZ;
  localparam int ATP_FIFO_DEPTH  = 512;
endpackage

// File: verilog/atp_trigger_pacer.sv
// Trigger, pacer, analog threshold and scan control for the ADC path
// Operation
// - Pacer source field picks software, counter, external falling or rising.
// - In software pacing, any word write to ADC data starts one conversion.
// - Scan/pacer read bit 14 shows live conversion-done level.
// - Trigger source field picks off, software, digital input or analog compare.
// - Inverter bit flips external trigger so internal sense is rising/high.
// - Edge/level bit makes external control an edge trigger or level gate.
// - Enable bit lets selected trigger act; cleared, it has no effect.
// - First qualified edge after enable sets flop; later ones ignored until cleared.
// - Writing one to clear bit resets the flop; zero leaves it alone.
// - Trigger read bit 7 returns the trigger flop state.
// - Burst enable scans from first to last channel; cleared disables burst.
// - Pre-trigger enable selects pre-trigger mode with counter and short FIFO.
// - No threshold enables gives hysteresis, direction set by hysteresis sense.
// - Lower only, upper only, or both give slope or window output.
// - Upper threshold from analog output 1, lower from 0; upper not below lower.
// - Normal mode arms counter by half-full or immediately per short FIFO mode.
// - Pre-trigger mode arms counter after flop set and index done.
// - User counter 0 clocks from 10 MHz when select is 1, else pin.
// - Trigger read bit 12 shows pre-trigger index counter complete.
// - Channel advances after each conversion, reloads first after last.
`timescale 1ns/10ps
module atp_trigger_pacer
  import atp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port (16-bit word I/O)
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic        data_wr,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  // Converter and counter status
  input  wire logic        conversion_done,
  input  wire logic        counter_pacer,
  input  wire logic        adc_fifo_half_full,
  input  wire logic        pre_index_done,
  // External signals
  input  wire logic        ext_trigger_pin,
  input  wire logic        ext_pacer_pin,
  input  wire logic        above_upper,
  input  wire logic        below_lower,
  input  wire logic        user_counter_clock_pin,
  // Outputs
  output logic             convert_start,
  output logic [3:0]       mux_channel,
  output logic             trigger_flop_state,
  output logic             acq_gate,
  output logic             analog_trigger_out,
  output logic             sample_counter_arm,
  output logic             sample_counter_clk_en,
  output logic             user_counter_clk_en,
  output logic             burst_mode,
  output logic             pretrig_mode
);

  ////////////////////////////////////////////////////////////////////////
  // Registers and decode
  logic [15:0] sp_ff;
  logic [15:0] tc_ff;
  logic        wr_sp;
  logic        wr_tc;
  logic [1:0]  pacer_source_select;
  logic [1:0]  trigger_source_select;
  logic [3:0]  scan_first_channel;
  logic [3:0]  scan_last_channel;
  logic        ext_trigger_invert;
  logic        edge_or_level_select;
  logic        ext_trigger_enable;
  logic        burst_scan_enable;
  logic        pretrigger_enable;
  logic        lower_threshold_enable;
  logic        upper_threshold_enable;
  logic        hysteresis_sense;
  logic        arm_bit;
  logic        short_fifo_mode;
  logic        user_counter_clock_select;
  logic        trigger_flop_clear;

  assign wr_sp = reg_wr && (reg_addr == ATP_OFF_SCAN_PACER);
  assign wr_tc = reg_wr && (reg_addr == ATP_OFF_TRIG_CTRL);
  assign scan_first_channel     = sp_ff[ATP_SP_FIRST_LSB +: 4];
  assign scan_last_channel      = sp_ff[ATP_SP_LAST_LSB +: 4];
  assign pacer_source_select    = sp_ff[ATP_SP_PACER_LSB +: 2];
  assign trigger_source_select  = tc_ff[ATP_TC_TSEL_LSB +: 2];
  assign ext_trigger_invert     = tc_ff[ATP_TC_INV_BIT];
  assign edge_or_level_select   = tc_ff[ATP_TC_EDGE_BIT];
  assign ext_trigger_enable     = tc_ff[ATP_TC_EN_BIT];
  assign burst_scan_enable      = tc_ff[ATP_TC_BURST_BIT];
  assign pretrigger_enable      = tc_ff[ATP_TC_PRE_BIT];
  assign lower_threshold_enable = tc_ff[ATP_TC_LOEN_BIT];
  assign upper_threshold_enable = tc_ff[ATP_TC_HIEN_BIT];
  assign hysteresis_sense       = tc_ff[ATP_TC_HYST_BIT];
  assign arm_bit                = tc_ff[ATP_TC_ARM_BIT];
  assign short_fifo_mode        = tc_ff[ATP_TC_SHORT_BIT];
  assign user_counter_clock_select = tc_ff[ATP_TC_UCLK_BIT];
  // Write-clear is a pulse on the write itself; nothing to store or reset
  assign trigger_flop_clear = wr_tc && reg_wdata[ATP_TC_CLR_BIT];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_ff <= ATP_SP_RESET;
    end else if (wr_sp) begin
      sp_ff <= {2'h0, reg_wdata[13:0]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tc_ff <= ATP_TC_RESET;
    end else if (wr_tc) begin
      // Clear bit is not kept, so it reads back as a status bit instead
      tc_ff <= {2'h0, reg_wdata[13:8], 1'b0, reg_wdata[6:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers: first stage is only read by the second
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  logic [4:0] prev_ff;
  logic [4:0] raw_in;

  assign raw_in = {user_counter_clock_pin, below_lower, above_upper,
                   ext_pacer_pin, ext_trigger_pin};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= 5'h00;
      sync2_ff <= 5'h00;
      prev_ff  <= 5'h00;
    end else begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Analog threshold logic over two comparator indications
  logic hi_s;
  logic lo_s;
  logic hyst_ff;
  logic ana_lvl;

  assign hi_s = sync2_ff[2];
  assign lo_s = sync2_ff[3];

  // Hysteresis state; thresholds are driven by analog outputs 1 and 0
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hyst_ff <= 1'b0;
    end else if (!hysteresis_sense) begin
      if (hi_s) begin
        hyst_ff <= 1'b1;
      end else if (lo_s) begin
        hyst_ff <= 1'b0;
      end
    end else begin
      if (lo_s) begin
        hyst_ff <= 1'b1;
      end else if (hi_s) begin
        hyst_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    case ({upper_threshold_enable, lower_threshold_enable})
      2'h1:    ana_lvl = lo_s;
      2'h2:    ana_lvl = hi_s;
      2'h3:    ana_lvl = !hi_s && !lo_s;
      default: ana_lvl = hyst_ff;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Trigger qualification and trigger flop
  logic ana_prev_ff;
  logic src_lvl;
  logic src_prev;
  logic src_edge;
  logic sw_trig;
  logic trig_ev;
  logic flop_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ana_prev_ff <= 1'b0;
    end else begin
      ana_prev_ff <= ana_lvl;
    end
  end

  // Software trigger fires on a write that selects the software source
  assign sw_trig = wr_tc && (reg_wdata[1:0] == ATP_TRIG_SW);

  always_comb begin
    case (trigger_source_select)
      ATP_TRIG_DIG: begin
        src_lvl  = sync2_ff[0] ^ ext_trigger_invert;
        src_prev = prev_ff[0] ^ ext_trigger_invert;
      end
      ATP_TRIG_ANA: begin
        src_lvl  = ana_lvl ^ ext_trigger_invert;
        src_prev = ana_prev_ff ^ ext_trigger_invert;
      end
      default: begin
        src_lvl  = 1'b0;
        src_prev = 1'b0;
      end
    endcase
  end

  assign src_edge = src_lvl && !src_prev;
  assign trig_ev  = ext_trigger_enable &&
                    (((trigger_source_select == ATP_TRIG_SW) && sw_trig) ||
                     (src_edge && edge_or_level_select));

  // Set wins over a simultaneous clear only while the flop is low; with the flop set, clear wins and that trigger is dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flop_ff <= 1'b0;
    end else if (trig_ev && !flop_ff) begin
      flop_ff <= 1'b1;
    end else if (trigger_flop_clear) begin
      flop_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pacing and conversion start
  logic pace_tick;
  logic gate_ok;
  logic ctr_prev_ff;
  logic data_wr_sw;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctr_prev_ff <= 1'b0;
    end else begin
      ctr_prev_ff <= counter_pacer;
    end
  end

  assign data_wr_sw = data_wr && (reg_addr == ATP_OFF_ADC_DATA);

  always_comb begin
    case (pacer_source_select)
      ATP_PACE_SW:   pace_tick = data_wr_sw;
      ATP_PACE_CTR:  pace_tick = counter_pacer && !ctr_prev_ff;
      ATP_PACE_FALL: pace_tick = !sync2_ff[1] && prev_ff[1];
      default:       pace_tick = sync2_ff[1] && !prev_ff[1];
    endcase
  end

  // Level gate or latched edge trigger; source off means free pacing, enable clear with a source selected shuts the gate
  always_comb begin
    if (trigger_source_select == ATP_TRIG_OFF || !ext_trigger_enable) begin
      gate_ok = (trigger_source_select == ATP_TRIG_OFF);
    end else if (!edge_or_level_select &&
                 trigger_source_select != ATP_TRIG_SW) begin
      gate_ok = src_lvl;
    end else begin
      gate_ok = flop_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      convert_start <= 1'b0;
      acq_gate      <= 1'b0;
    end else begin
      // Software conversions bypass triggering; data value ignored
      convert_start <= pace_tick &&
                       (gate_ok || pacer_source_select == ATP_PACE_SW);
      acq_gate      <= gate_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Channel scan: load first on write, step on each conversion
  logic done_prev_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_prev_ff <= 1'b1;
    end else begin
      done_prev_ff <= conversion_done;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mux_channel <= 4'h0;
    end else if (wr_sp) begin
      mux_channel <= reg_wdata[ATP_SP_FIRST_LSB +: 4];
    end else if (conversion_done && !done_prev_ff) begin
      if (mux_channel == scan_last_channel) begin
        mux_channel <= scan_first_channel;
      end else begin
        mux_channel <= mux_channel + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sample counter arming and clock source
  logic [4:0] ref_cnt_ff;
  logic       ref_tick;
  logic       arm_ok;

  assign ref_tick = (ref_cnt_ff == 5'(ATP_REF_DIV - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_cnt_ff <= 5'h00;
    end else if (ref_tick) begin
      ref_cnt_ff <= 5'h00;
    end else begin
      ref_cnt_ff <= ref_cnt_ff + 5'h01;
    end
  end

  // Pre-trigger arming only takes once trigger and index are complete
  assign arm_ok = arm_bit &&
                  (!pretrigger_enable || (flop_ff && pre_index_done));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_counter_arm    <= 1'b0;
      sample_counter_clk_en <= 1'b0;
      user_counter_clk_en   <= 1'b0;
      burst_mode            <= 1'b0;
      pretrig_mode          <= 1'b0;
      trigger_flop_state    <= 1'b0;
      analog_trigger_out    <= 1'b0;
    end else begin
      sample_counter_arm    <= arm_ok;
      sample_counter_clk_en <= arm_ok && (short_fifo_mode ?
                               pace_tick : adc_fifo_half_full);
      user_counter_clk_en   <= user_counter_clock_select ? ref_tick :
                               (sync2_ff[4] && !prev_ff[4]);
      burst_mode            <= burst_scan_enable;
      pretrig_mode          <= pretrigger_enable;
      trigger_flop_state    <= flop_ff;
      analog_trigger_out    <= ana_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr == ATP_OFF_SCAN_PACER) begin
        reg_rdata <= 16'(conversion_done) << ATP_SP_DONE_BIT;
      end else if (reg_addr == ATP_OFF_TRIG_CTRL) begin
        reg_rdata <= (16'(flop_ff) << ATP_TC_FLOP_BIT) |
                     (16'(pre_index_done) << ATP_TC_INDEX_BIT);
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end

endmodule // atp_trigger_pacer
